// ==== design/mbc_pkg.sv ====
// Functional notes
// - Host drives the 8-bit device number on the byte lines before select.
// - Host-to-device byte lines are active low on the bus.
// - Host then raises select strobe to mark the byte as an address.
// - On reply host drops select and number; controller then drops reply.
// - Read request to selected controller: it drives data byte and raises reply.
// - Host drops read request after storing; controller drops reply and data.
// - Host aborts and flags overflow if no reply within 50 to 100 us.
// - For write, host places data byte then raises write strobe.
// - On write reply host drops strobe and data; controller drops reply.
// - Status request to selected controller: it drives status byte and replies.
// - Host stores status byte and copies bits 4..7 into condition code.
// - Host drops status request; controller drops reply and status byte.
package mbc_pkg;
  // Register offsets
  localparam logic [11:0] REG_CMD    = 12'h000;
  localparam logic [11:0] REG_DATA   = 12'h004;
  localparam logic [11:0] REG_RESULT = 12'h008;
  localparam logic [11:0] REG_IRQST  = 12'h00C;
  localparam logic [11:0] REG_IRQEN  = 12'h010;
  localparam logic [11:0] REG_IRQCLR = 12'h014;
  // Command register fields
  localparam int CMD_OP_LSB  = 8;
  localparam int CMD_GO_BIT  = 31;
  // Result register fields
  localparam int RES_CC_LSB  = 8;
  localparam int RES_BUSY    = 16;
  localparam int RES_TOUT    = 17;
  // Interrupt status bits
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_TOUT    = 1;
  // Timeout: the reply must come within 50 us; abort at 75 us, inside 50..100
  localparam int  TIMEOUT_NS     = 75000;
  localparam int  CLK_PERIOD_NS  = 10;
  localparam int  TIMEOUT_CYCLES = TIMEOUT_NS / CLK_PERIOD_NS;
  // Bus operations
  typedef enum logic [1:0] {
    OP_READ   = 2'b00,
    OP_WRITE  = 2'b01,
    OP_STATUS = 2'b10,
    OP_SELECT = 2'b11
  } mbc_op_t;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_ADDROFF = 3'b010,
    ST_XFER    = 3'b011,
    ST_XFEROFF = 3'b100
  } mbc_state_t;
endpackage

// ==== design/mbc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbc_host #(
  parameter int TIMEOUT = mbc_pkg::TIMEOUT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic [7:0]       hostToDeviceLines_n,
  output logic             selectStrobe,
  output logic             readRequest,
  output logic             writeStrobe,
  output logic             statusRequest,
  output logic             systemClearLine,
  input  wire logic [7:0]  deviceToHostLines_n,
  input  wire logic        handshakeReply
);
  import mbc_pkg::*;

  // Register map seen by software, one aligned word each:
  //   CMD    wr: [7:0] device number, [9:8] operation, bit30 system clear pulse, bit31 go
  //          rd: operation and device number of the last accepted command
  //   DATA   wr: [7:0] byte for the next write operation; rd: that byte
  //   RESULT ro: [7:0] byte returned by a read or status operation
  //              [11:8] condition code, the upper half of the last status byte
  //              bit16 busy, bit17 the last operation ended without a reply
  //   IRQST  ro: bit0 operation done, bit1 reply timeout; sticky
  //   IRQEN  rw: same layout, gates the level interrupt
  //   IRQCLR wo: a one clears the matching sticky bit
  // CMD and DATA writes are ignored while busy, so a running transfer never sees
  // its device number or data byte change underneath it.
  //
  // Operation flow on the device side:
  //   IDLE    -> ADDR    : device number placed on the byte lines
  //   ADDR    -> ADDROFF : select strobe raised, reply seen, strobe and number dropped
  //   ADDROFF -> XFER    : reply gone; for a write the data byte is placed now
  //   XFER    -> XFEROFF : request raised, reply seen, read or status byte captured, request dropped
  //   XFEROFF -> IDLE    : reply gone, operation done
  // One reply timer, started at go, spans all phases; running out aborts to IDLE with the
  // timeout flag set, so a missing or dead device never locks the sequencer.
  // Limitation: a device that keeps its reply up after the abort is not
  // disconnected here; software should pulse system clear before retrying.

  mbc_state_t  state_q;
  mbc_op_t     op_q;
  logic [7:0]  devNum_q;
  logic [7:0]  wrData_q;
  logic [7:0]  rdData_q;
  logic [3:0]  condCode_q;
  logic        timeout_q;
  logic [1:0]  irqSt_q;
  logic [1:0]  irqEn_q;
  logic        clrReq_q;
  logic [31:0] timer_q;
  logic        doneEv;
  logic        toutEv;
  logic        busWr;
  logic        busRd;
  logic        go;
  logic        timerHit;
  logic [1:0]  irqSet;

  assign busWr = psel && penable && pwrite;
  assign busRd = psel && !penable && !pwrite;
  assign go    = busWr && paddr == REG_CMD && pwdata[CMD_GO_BIT] && state_q == ST_IDLE;
  assign timerHit = timer_q >= TIMEOUT[31:0] - 32'h00000001;

  // Slave answers in the access cycle itself; every address is mapped or reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
    end
  end

  // Read data is prepared during setup so it stands at the access edge
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (busRd) begin
      unique case (paddr)
        REG_DATA:   prdata <= {24'h000000, wrData_q};
        REG_RESULT: prdata <= {14'h0000, timeout_q, state_q != ST_IDLE, 4'h0, condCode_q, rdData_q};
        REG_IRQST:  prdata <= {30'h00000000, irqSt_q};
        REG_IRQEN:  prdata <= {30'h00000000, irqEn_q};
        REG_CMD:    prdata <= {16'h0000, 6'h00, op_q, devNum_q};
        default:    prdata <= 32'h00000000;
      endcase
    end
  end

  // Software writes: command fields, data, enable and system clear request
  always_ff @(posedge clk) begin
    if (srst) begin
      op_q     <= OP_SELECT;
      devNum_q <= 8'h00;
      wrData_q <= 8'h00;
      irqEn_q  <= 2'h0;
      clrReq_q <= 1'b0;
    end else begin
      clrReq_q <= 1'b0;
      if (busWr && paddr == REG_CMD && state_q == ST_IDLE) begin
        devNum_q <= pwdata[7:0];
        op_q     <= mbc_op_t'(pwdata[CMD_OP_LSB +: 2]);
        clrReq_q <= pwdata[30];
      end
      if (busWr && paddr == REG_DATA && state_q == ST_IDLE) begin
        wrData_q <= pwdata[7:0];
      end
      if (busWr && paddr == REG_IRQEN) begin
        irqEn_q <= pwdata[1:0];
      end
    end
  end

  // Handshake sequencer; select phase then, for read, write and status, one data phase, each fully interlocked
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q             <= ST_IDLE;
      hostToDeviceLines_n <= 8'hFF;
      selectStrobe        <= 1'b0;
      readRequest         <= 1'b0;
      writeStrobe         <= 1'b0;
      statusRequest       <= 1'b0;
      rdData_q            <= 8'h00;
      condCode_q          <= 4'h0;
      timeout_q           <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (go) begin
            // Number goes out first, strobe follows one cycle later
            hostToDeviceLines_n <= ~pwdata[7:0];
            timeout_q           <= 1'b0;
            state_q             <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          selectStrobe <= 1'b1;
          if (selectStrobe && handshakeReply) begin
            selectStrobe        <= 1'b0;
            hostToDeviceLines_n <= 8'hFF;
            state_q             <= ST_ADDROFF;
          end else if (timerHit) begin
            selectStrobe        <= 1'b0;
            hostToDeviceLines_n <= 8'hFF;
            timeout_q           <= 1'b1;
            state_q             <= ST_IDLE;
          end
        end
        ST_ADDROFF: begin
          // Wait for the reply to fall before any data request
          if (!handshakeReply) begin
            if (op_q == OP_SELECT) begin
              state_q <= ST_IDLE;
            end else begin
              if (op_q == OP_WRITE) begin
                hostToDeviceLines_n <= ~wrData_q;
              end
              state_q <= ST_XFER;
            end
          end else if (timerHit) begin
            timeout_q <= 1'b1;
            state_q   <= ST_IDLE;
          end
        end
        ST_XFER: begin
          readRequest   <= op_q == OP_READ;
          writeStrobe   <= op_q == OP_WRITE;
          statusRequest <= op_q == OP_STATUS;
          if ((readRequest || writeStrobe || statusRequest) && handshakeReply) begin
            if (op_q != OP_WRITE) begin
              // Return byte is active low as well; stored in true polarity
              rdData_q <= ~deviceToHostLines_n;
            end
            if (op_q == OP_STATUS) begin
              condCode_q <= ~deviceToHostLines_n[7:4];
            end
            readRequest         <= 1'b0;
            writeStrobe         <= 1'b0;
            statusRequest       <= 1'b0;
            hostToDeviceLines_n <= 8'hFF;
            state_q             <= ST_XFEROFF;
          end else if (timerHit) begin
            readRequest         <= 1'b0;
            writeStrobe         <= 1'b0;
            statusRequest       <= 1'b0;
            hostToDeviceLines_n <= 8'hFF;
            timeout_q           <= 1'b1;
            state_q             <= ST_IDLE;
          end
        end
        ST_XFEROFF: begin
          if (!handshakeReply || timerHit) begin
            timeout_q <= handshakeReply;
            state_q   <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Reply timer clears only in IDLE or on go; it runs on across all phases of an operation
  always_ff @(posedge clk) begin
    if (srst) begin
      timer_q <= 32'h00000000;
    end else if (state_q == ST_IDLE || go) begin
      timer_q <= 32'h00000000;
    end else begin
      timer_q <= timer_q + 32'h00000001;
    end
  end

  // Pulse system clear for one cycle on request; it drops every selection latch
  always_ff @(posedge clk) begin
    if (srst) begin
      systemClearLine <= 1'b0;
    end else begin
      systemClearLine <= clrReq_q;
    end
  end

  assign doneEv = state_q != ST_IDLE && ((state_q == ST_XFEROFF && !handshakeReply) ||
                  (state_q == ST_ADDROFF && !handshakeReply && op_q == OP_SELECT));
  // Timeout event mirrors exactly the abort branches of the sequencer:
  // a reply, or in ADDROFF and XFEROFF its fall, seen in the same cycle as the timer end counts as success
  assign toutEv = timerHit && (
                  (state_q == ST_ADDR && !(selectStrobe && handshakeReply)) ||
                  (state_q == ST_ADDROFF && handshakeReply) ||
                  (state_q == ST_XFER && !((readRequest || writeStrobe || statusRequest) && handshakeReply)) ||
                  (state_q == ST_XFEROFF && handshakeReply));

  // Event sources gathered by bit position
  assign irqSet[IRQ_DONE] = doneEv;
  assign irqSet[IRQ_TOUT] = toutEv;

  // Sticky events, one flop per bit; a set in the same cycle as a clear wins
  for (genvar g = 0; g < 2; g++) begin : g_irq
    always_ff @(posedge clk) begin
      if (srst) begin
        irqSt_q[g] <= 1'b0;
      end else if (irqSet[g]) begin
        irqSt_q[g] <= 1'b1;
      end else if (busWr && paddr == REG_IRQCLR && pwdata[g]) begin
        irqSt_q[g] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqSt_q & irqEn_q);
    end
  end
endmodule // mbc_host
`default_nettype wire

// ==== tb/mbc_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbc_dev #(
  parameter logic [7:0] OWN_ADDR = 8'h22
) (
  input  wire logic [7:0] hostToDeviceLines_n,
  input  wire logic       clk,
  input  wire logic       systemClearLine,
  input  wire logic       selectStrobe,
  input  wire logic       readRequest,
  input  wire logic       writeStrobe,
  input  wire logic       statusRequest,
  input  wire logic       stall,
  input  wire logic [7:0] dataByte,
  input  wire logic [7:0] statusByte,
  output logic [7:0]      deviceToHostLines_n,
  output logic            handshakeReply,
  output logic [7:0]      outByte
);
  logic selLatch_q;
  logic hit;
  logic idle_q = 1'b0;
  // Ones travel as low levels
  assign hit = (~hostToDeviceLines_n == OWN_ADDR);
  // Every address cycle reloads the latch, so a foreign address disconnects
  always_ff @(posedge clk)
    if (systemClearLine) selLatch_q <= 1'b0;
    else if (selectStrobe) selLatch_q <= hit;
  // Registered reply; a stalled device simply answers later
  always_ff @(posedge clk)
    handshakeReply <= !stall && (selectStrobe ? hit : selLatch_q && (readRequest || writeStrobe || statusRequest));
  // Output register
  always_ff @(posedge clk)
    if (selLatch_q && writeStrobe) outByte <= ~hostToDeviceLines_n;
  always_ff @(posedge clk) idle_q <= !idle_q;
  // Released lines toggle so a stale byte never passes for data
  always_comb
    if (selLatch_q && readRequest) deviceToHostLines_n = ~dataByte;
    else if (selLatch_q && statusRequest) deviceToHostLines_n = ~statusByte;
    else deviceToHostLines_n = {8{idle_q}};
endmodule // mbc_dev
`default_nettype wire

// ==== tb/mbc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mbc_chk (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic [7:0] hostToDeviceLines_n,
  input wire logic       selectStrobe,
  input wire logic       readRequest,
  input wire logic       writeStrobe,
  input wire logic       statusRequest,
  input wire logic       handshakeReply
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ack(logic req);
    req && handshakeReply;
  endsequence
  // A request falls soon after its reply
  property p_drop(logic req);
    s_ack(req) |-> ##[1:4] !req;
  endproperty
  a_sel_drop: assert property (p_drop(selectStrobe))
    else $error("select held");
  a_rd_drop: assert property (p_drop(readRequest))
    else $error("read held");
  a_wr_drop: assert property (p_drop(writeStrobe))
    else $error("write held");
  a_st_drop: assert property (p_drop(statusRequest))
    else $error("status held");
  // Byte settles before its strobe and leaves with the address
  a_addr_first: assert property ($rose(selectStrobe) |-> $stable(hostToDeviceLines_n))
    else $error("address late");
  a_data_first: assert property ($rose(writeStrobe) |-> $stable(hostToDeviceLines_n))
    else $error("data late");
  a_addr_gone: assert property ($fell(selectStrobe) |-> hostToDeviceLines_n == 8'hFF)
    else $error("address kept");
  // Two orders at once would confuse every device
  a_one_ctrl: assert property ($onehot0({selectStrobe, readRequest, writeStrobe, statusRequest}))
    else $error("two strobes");
endmodule // mbc_chk
bind mbc_host mbc_chk i_mbc_chk (.*);
`default_nettype wire

// ==== tb/test_mux_bus_device_controller_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_mux_bus_device_controller_port;
  import mbc_pkg::*;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq, stall;
  logic        selectStrobe, readRequest, writeStrobe, statusRequest, systemClearLine, handshakeReply;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  hostToDeviceLines_n, deviceToHostLines_n, dataByte, statusByte, outByte;
  int          errors, n_checks;
  // Short timeout keeps the abort case quick
  mbc_host #(.TIMEOUT(50)) i_mbc_host (.*);
  mbc_dev i_mbc_dev (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic lim(input int n, input int m);
    if (n >= m) begin
      errors++;
      results();
    end
  endtask
  // One APB transfer; leading edge keeps back-to-back calls apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    chk("slverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    lim(n, 20);
  endtask
  // Start a bus operation, poll until not busy; r ends as the result word
  task automatic op(input logic [9:0] c);
    int n;
    n = 0;
    apb(1'b1, REG_CMD, 32'h8000_0000 | c);
    do begin
      apb(1'b0, REG_RESULT, 32'h0);
      n++;
    end while (r[RES_BUSY] !== 1'b0 && n < 300);
    lim(n, 300);
  endtask
  initial begin
    {srst, psel, penable, pwrite, stall} = 5'h10;
    paddr = 12'h0;
    pwdata = 32'h0;
    dataByte = 8'h3C;
    statusByte = 8'hB4;
    errors = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, REG_RESULT, 32'h0);
    chk("result", 32'h0, r);
    apb(1'b1, REG_IRQEN, 32'h3);
    // Slow device on the address phase
    stall <= 1'b1;
    fork
      op({OP_SELECT, 8'h22});
      begin
        repeat (20) @(posedge clk);
        stall <= 1'b0;
      end
    join
    apb(1'b0, REG_IRQST, 32'h0);
    chk("done", 32'h1, r);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, REG_IRQCLR, 32'h3);
    apb(1'b0, REG_IRQST, 32'h0);
    chk("irq clr", 32'h0, {r[30:0], irq});
    apb(1'b1, REG_DATA, 32'hA5);
    op({OP_WRITE, 8'h22});
    chk("out", 32'hA5, {24'h0, outByte});
    op({OP_READ, 8'h22});
    chk("rd", 32'h3C, r & 32'hFF);
    op({OP_STATUS, 8'h22});
    chk("st", 32'hBB4, r & 32'hFFF);
    // System clear alone drops the latch of the selected device
    chk("latched", 32'h1, {31'h0, i_mbc_dev.selLatch_q});
    apb(1'b1, REG_CMD, 32'h4000_0000);
    repeat (3) @(posedge clk);
    chk("cleared", 32'h0, {31'h0, i_mbc_dev.selLatch_q});
    // Foreign address: nobody answers
    op({OP_READ, 8'h55});
    chk("tout", 32'h0002_0000, r & 32'h0002_0000);
    apb(1'b1, REG_IRQEN, 32'h0);
    apb(1'b0, REG_IRQST, 32'h0);
    chk("masked", 32'h1, {r[31:2], irq, r[1]});
    apb(1'b1, REG_IRQEN, 32'h2);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped", 32'h1, {r[30:0], irq});
    results();
  end
endmodule // test_mux_bus_device_controller_port
`default_nettype wire
